//--- rtl/epm_cfg.svh
`ifndef EPM_CFG_SVH
`define EPM_CFG_SVH

// Pin function select codes, three bits per pin.
`define EPM_SEL_MEM        3'h0
`define EPM_SEL_GPO        3'h1
`define EPM_SEL_MON_EN     3'h2
`define EPM_SEL_MON_CLK    3'h3

// Reset values.
`define EPM_SEL_RST        3'h0
`define EPM_WIDTH_RST      1'b0

// Power-on reset stretch in core clock cycles.
`define EPM_POR_CYCLES     4'hf

`endif

//--- rtl/epm_pkg.sv
package epm_pkg;
   `include "epm_cfg.svh"

   typedef logic [2:0] epm_sel_t;

   typedef enum logic [1:0] {
      EPM_IN_RESET,
      EPM_WAIT_READ,
      EPM_ARMED
   } epm_gate_e;
endpackage

//--- rtl/epm_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the raw pin levels into the synchroniser and the clean levels back.
interface epm_sync_if;
   logic [3:0] raw;
   logic [3:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

`default_nettype wire

//--- rtl/epm_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin levels entering the core clock domain.
module epm_sync (
   input  wire logic  core_clk,
   input  wire logic  rst,
   epm_sync_if.sync   sif
);
   logic [3:0] meta_q;
   logic [3:0] clean_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q  <= 4'h0;
         clean_q <= 4'h0;
      end else begin
         meta_q  <= sif.raw;
         clean_q <= meta_q;
      end
   end

   assign sif.clean = clean_q;
endmodule

`default_nettype wire

//--- rtl/epm_pin_mux.sv
// Notes on behaviour
// - Data pin is bidirectional in memory role, reaching the memory data line through output registers and a two-stage input synchroniser.
// - Data pin may instead be general output three or transmit enable/clock monitor; its clock monitor code 3'h3 drives the synchronised transmit clock.
// - Data pin in output or monitor role forces the memory select inactive.
// - Neither pin gives a general input in its alternate roles; outputs only.
// - Data pin is latched at reset release: high is 32-bit bus, low 16-bit.
// - Clock pin drives memory clock, or general output four, or receive monitors.
// - A dedicated active-low output is the memory chip select.
// - Logic runs from the 25 MHz crystal clock.
// - External active-low reset returns all logic to reset state.
// - With reset pin floating, internal power-on reset takes over.
// - Writes are ignored until one read occurs after reset or power saving.
`timescale 1ns/1ps
`default_nettype none
`include "epm_cfg.svh"

module epm_pin_mux
   import epm_pkg::*;
(
   input  wire logic           core_clk,
   input  wire logic           rst,
   input  wire logic           external_reset_n,
   input  wire logic           power_on_done,
   input  wire epm_pkg::epm_sel_t data_sel,
   input  wire epm_pkg::epm_sel_t clock_sel,
   input  wire logic           sel_write,
   input  wire logic           host_read,
   input  wire logic           power_save_exit,
   input  wire logic           general_output_three,
   input  wire logic           general_output_four,
   input  wire logic           mii_tx_en,
   input  wire logic           mii_tx_clk,
   input  wire logic           mii_rx_dv,
   input  wire logic           mii_rx_clk,
   input  wire logic           mem_data_out,
   input  wire logic           mem_data_drive,
   input  wire logic           mem_clock,
   input  wire logic           serial_mem_select,
   input  wire logic           serial_mem_data_pin_in,
   output logic                serial_mem_data_pin_out,
   output logic                serial_mem_data_pin_oe_n,
   output logic                serial_mem_clock_pin,
   output logic                serial_mem_select_n,
   output logic                mem_data_in,
   output logic                bus_width_strap,
   output logic                writes_enabled,
   output logic                core_reset
);
   import epm_pkg::*;

   // ----------------------------------------------------------------------
   // Reset combination and synchronisation
   // ----------------------------------------------------------------------
   epm_sync_if sif ();
   logic       rst_any;
   logic       rst_meta_q;
   logic       rst_sync_q;
   logic [3:0] por_cnt_q;

   // Any of the three reset sources drives the internal reset; a floating pin reads high.
   assign rst_any = rst | ~external_reset_n | ~power_on_done;

   // Asynchronous assert, synchronous release of the internal reset.
   always_ff @(posedge core_clk or posedge rst_any) begin
      if (rst_any) begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= 1'b1;
      end else begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Stretch the reset so the strap settles before it is caught.
   always_ff @(posedge core_clk or posedge rst_sync_q) begin
      if (rst_sync_q) begin
         por_cnt_q <= 4'h0;
      end else if (por_cnt_q != `EPM_POR_CYCLES) begin
         por_cnt_q <= por_cnt_q + 4'h1;
      end
   end

   assign core_reset = rst_sync_q | (por_cnt_q != `EPM_POR_CYCLES);

   // ----------------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------------
   assign sif.raw = {mii_rx_clk, mii_tx_clk, 1'b0, serial_mem_data_pin_in};

   epm_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst_sync_q),
      .sif      (sif)
   );

   assign mem_data_in = sif.clean[0];

   // ----------------------------------------------------------------------
   // Bus width strap
   // ----------------------------------------------------------------------
   logic strap_taken_q;
   logic width_q;

   // Catch the data pin once at the end of the reset stretch.
   always_ff @(posedge core_clk or posedge rst_sync_q) begin
      if (rst_sync_q) begin
         strap_taken_q <= 1'b0;
         width_q       <= `EPM_WIDTH_RST;
      end else if (!strap_taken_q && core_reset) begin
         width_q <= sif.clean[0];
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
      end
   end

   assign bus_width_strap = width_q;  // High selects a 32-bit host bus.

   // ----------------------------------------------------------------------
   // Read-before-write gate
   // ----------------------------------------------------------------------
   epm_gate_e gate_q;

   // Writes stay blocked until a read is seen after reset or a wake-up.
   always_ff @(posedge core_clk or posedge rst_sync_q) begin
      if (rst_sync_q) begin
         gate_q <= EPM_IN_RESET;
      end else begin
         case (gate_q)
            EPM_IN_RESET:  gate_q <= core_reset ? EPM_IN_RESET : EPM_WAIT_READ;
            EPM_WAIT_READ: gate_q <= host_read ? EPM_ARMED : EPM_WAIT_READ;
            EPM_ARMED:     gate_q <= (power_save_exit && !host_read) ? EPM_WAIT_READ
                                                                      : EPM_ARMED;
            default:       gate_q <= EPM_IN_RESET;
         endcase
      end
   end

   assign writes_enabled = (gate_q == EPM_ARMED);

   // ----------------------------------------------------------------------
   // Function select registers
   // ----------------------------------------------------------------------
   epm_sel_t data_sel_q;
   epm_sel_t clock_sel_q;

   // Software sets the roles only through an accepted write.
   always_ff @(posedge core_clk or posedge rst_sync_q) begin
      if (rst_sync_q) begin
         data_sel_q  <= `EPM_SEL_RST;
         clock_sel_q <= `EPM_SEL_RST;
      end else if (sel_write && writes_enabled && !core_reset) begin
         data_sel_q  <= data_sel;
         clock_sel_q <= clock_sel;
      end
   end

   // Returns the output level chosen for a pin from its select code.
   function automatic logic pick(input epm_sel_t sel, input logic mem, input logic gpo,
                                 input logic mon_en, input logic mon_clk);
      case (sel)
         `EPM_SEL_MEM:     pick = mem;
         `EPM_SEL_GPO:     pick = gpo;
         `EPM_SEL_MON_EN:  pick = mon_en;
         `EPM_SEL_MON_CLK: pick = mon_clk;
         default:          pick = mem;
      endcase
   endfunction

   // True for the output and monitor roles; unused codes fall back to the memory role.
   function automatic logic is_alt(input epm_sel_t sel);
      is_alt = (sel == `EPM_SEL_GPO) || (sel == `EPM_SEL_MON_EN) || (sel == `EPM_SEL_MON_CLK);
   endfunction

   // ----------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------
   logic data_alt;
   logic clock_alt;
   logic data_out_q;
   logic data_oe_n_q;
   logic clock_q;
   logic select_n_q;

   assign data_alt  = is_alt(data_sel_q);
   assign clock_alt = is_alt(clock_sel_q);

   // Register every pin output; alternate roles always drive, never listen.
   always_ff @(posedge core_clk or posedge rst_sync_q) begin
      if (rst_sync_q) begin
         data_out_q  <= 1'b0;
         data_oe_n_q <= 1'b1;
         clock_q     <= 1'b0;
         select_n_q  <= 1'b1;
      end else begin
         data_out_q  <= pick(data_sel_q, mem_data_out, general_output_three,
                             mii_tx_en, sif.clean[2]);
         // The data pin is released during the stretch so the strap level can be caught.
         data_oe_n_q <= core_reset ? 1'b1 : (data_alt ? 1'b0 : ~mem_data_drive);
         clock_q     <= pick(clock_sel_q, mem_clock, general_output_four,
                             mii_rx_dv, sif.clean[3]);
         select_n_q  <= (data_alt || clock_alt || core_reset) ? 1'b1
                                                              : ~serial_mem_select;
      end
   end

   assign serial_mem_data_pin_out  = data_out_q;
   assign serial_mem_data_pin_oe_n = data_oe_n_q;
   assign serial_mem_clock_pin     = clock_q;
   assign serial_mem_select_n      = select_n_q;
endmodule

`default_nettype wire

//--- test/epm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module epm_mem_model (
   input  wire logic clk_pin,
   input  wire logic sel_n,
   input  wire logic din,
   input  wire logic reply,
   output logic      dout,
   output logic      doe
);
   logic [7:0] sh_q = 8'h96;

   // Shifts the data line in on each clock rise while the part is selected.
   always @(posedge clk_pin) begin
      if (!sel_n) begin
         sh_q <= {sh_q[6:0], din};
      end
   end

   // Drives the shared data line only while selected and told to answer.
   assign dout = sh_q[7];
   assign doe  = !sel_n && reply;
endmodule

`default_nettype wire

//--- test/epm_pin_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module epm_pin_mux_assertions
   import epm_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              core_reset,
   input  wire logic              writes_enabled,
   input  wire logic              host_read,
   input  wire logic              sel_write,
   input  wire epm_pkg::epm_sel_t data_sel,
   input  wire epm_pkg::epm_sel_t clock_sel,
   input  wire logic              general_output_three,
   input  wire logic              general_output_four,
   input  wire logic              mii_tx_en,
   input  wire logic              mem_clock,
   input  wire logic              mem_data_drive,
   input  wire logic              serial_mem_select,
   input  wire logic              serial_mem_data_pin_out,
   input  wire logic              serial_mem_data_pin_oe_n,
   input  wire logic              serial_mem_clock_pin,
   input  wire logic              serial_mem_select_n,
   input  wire logic              bus_width_strap
);
   epm_sel_t dq_q;
   epm_sel_t cq_q;
   logic     up_q;

   // Shadows the accepted roles; up_q marks pins computed outside reset.
   always_ff @(posedge core_clk or posedge core_reset) begin
      if (core_reset) begin
         dq_q <= 3'h0;
         cq_q <= 3'h0;
         up_q <= 1'b0;
      end else begin
         up_q <= 1'b1;
         if (sel_write && writes_enabled) begin
            dq_q <= data_sel;
            cq_q <= clock_sel;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (core_reset);

   a_reset_idle: assert property (disable iff (1'b0) core_reset |-> serial_mem_select_n
      && serial_mem_data_pin_oe_n && !writes_enabled) else $error("pins active in reset");
   a_strap_frozen: assert property (up_q |-> $stable(bus_width_strap))
      else $error("width strap moved");
   a_read_arms: assert property (up_q && host_read && !writes_enabled |=> writes_enabled)
      else $error("read did not arm writes");
   a_data_gpo: assert property (up_q && $past(dq_q) == 3'h1 |-> !serial_mem_data_pin_oe_n
      && serial_mem_data_pin_out == $past(general_output_three)) else $error("data gpo wrong");
   a_data_mon: assert property (up_q && $past(dq_q) == 3'h2 |-> !serial_mem_data_pin_oe_n
      && serial_mem_data_pin_out == $past(mii_tx_en)) else $error("data monitor wrong");
   a_clock_gpo: assert property (up_q && $past(cq_q) == 3'h1
      |-> serial_mem_clock_pin == $past(general_output_four)) else $error("clock gpo wrong");
   a_alt_deselect: assert property (up_q && ($past(dq_q) inside {3'h1, 3'h2, 3'h3}
      || $past(cq_q) inside {3'h1, 3'h2, 3'h3}) |-> serial_mem_select_n) else $error("select on");
   a_mem_role: assert property (up_q && $past(dq_q) == 3'h0 && $past(cq_q) == 3'h0
      |-> serial_mem_select_n == !$past(serial_mem_select) && serial_mem_clock_pin == $past(mem_clock)
      && serial_mem_data_pin_oe_n == !$past(mem_data_drive)) else $error("memory role wrong");

   c_armed: cover property (host_read ##1 writes_enabled);
   c_write: cover property (sel_write && writes_enabled);
   c_tx_clk: cover property (up_q && dq_q == 3'h3);
endmodule

bind epm_pin_mux epm_pin_mux_assertions i_epm_pin_mux_assertions (.*);

`default_nettype wire

//--- test/eeprom_pin_mux_strap_test.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_pin_mux_strap_test;
   import epm_pkg::*;
   logic     core_clk, rst, ext_n, por, sw, hr, pse, g3, g4, te, tc, rv, rc, md, mdd, mc, ms;
   logic     reply, strap_v, pin, po, poe_n, cp, csn, mdi, bw, we, cr, m_d, m_oe;
   epm_sel_t ds, cs;
   int       failures, checked;

   // Resolves the shared data line: device, then memory, then the strap resistor.
   assign pin = !poe_n ? po : (m_oe ? m_d : strap_v);

   epm_pin_mux i_epm_pin_mux (.core_clk(core_clk), .rst(rst), .external_reset_n(ext_n),
      .power_on_done(por), .data_sel(ds), .clock_sel(cs), .sel_write(sw), .host_read(hr),
      .power_save_exit(pse), .general_output_three(g3), .general_output_four(g4),
      .mii_tx_en(te), .mii_tx_clk(tc), .mii_rx_dv(rv), .mii_rx_clk(rc), .mem_data_out(md),
      .mem_data_drive(mdd), .mem_clock(mc), .serial_mem_select(ms), .serial_mem_data_pin_in(pin),
      .serial_mem_data_pin_out(po), .serial_mem_data_pin_oe_n(poe_n), .serial_mem_clock_pin(cp),
      .serial_mem_select_n(csn), .mem_data_in(mdi), .bus_width_strap(bw), .writes_enabled(we),
      .core_reset(cr));
   epm_mem_model i_epm_mem_model (.clk_pin(cp), .sel_n(csn), .din(pin), .reply(reply),
      .dout(m_d), .doe(m_oe));

   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic chk(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask

   task automatic final_report;
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Resets from one source with the strap level given, then waits out the stretch.
   task automatic do_reset(input int src, input logic s);
      strap_v = s;
      rst = (src == 0);
      ext_n = (src != 1);
      por = (src != 2);
      tick(3);
      rst = 1'b0;
      ext_n = 1'b1;
      por = 1'b1;
      for (int k = 0; cr !== 1'b0; k++) begin
         if (k > 40) begin
            failures++;
            final_report();
         end
         tick(1);
      end
      tick(1);
   endtask

   task automatic wsel(input epm_sel_t d, input epm_sel_t c);
      ds = d;
      cs = c;
      sw = 1'b1;
      tick(1);
      sw = 1'b0;
      tick(2);
   endtask

   // Main sequence.
   initial begin
      {sw, hr, pse, g3, g4, te, tc, rv, rc, md, mdd, mc, ms, reply} = 14'h0000;
      ds = 3'h0;
      cs = 3'h0;
      do_reset(0, 1'b1);
      chk("strap", 1'b1, bw);
      chk("armed", 1'b0, we);
      chk("select_n", 1'b1, csn);
      {ms, mc, mdd, md} = 4'hf;
      tick(2);
      chk("select_n", 1'b0, csn);
      chk("clock_pin", 1'b1, cp);
      chk("oe_n", 1'b0, poe_n);
      chk("pin_out", 1'b1, po);
      {mdd, mc, reply} = 3'h1;
      tick(4);
      chk("data_in", m_d, mdi);
      reply = 1'b0;
      wsel(3'h1, 3'h1);
      chk("refused", 1'b0, csn);
      hr = 1'b1;
      tick(1);
      hr = 1'b0;
      chk("armed", 1'b1, we);
      // GPO three and transmit enable high, GPO four low, receive valid high.
      {g3, te, g4, rv} = 4'hd;
      for (int k = 1; k < 4; k++) begin
         wsel(3'(k), 3'h0);
         chk("d_select_n", 1'b1, csn);
         chk("d_oe_n", 1'b0, poe_n);
         chk("d_out", k < 3, po);
      end
      for (int k = 1; k < 4; k++) begin
         wsel(3'h0, 3'(k));
         chk("c_select_n", 1'b1, csn);
         chk("c_pin", k == 2, cp);
      end
      wsel(3'h4, 3'h0);
      chk("d_code4", 1'b0, csn);
      wsel(3'h1, 3'h0);
      pse = 1'b1;
      tick(1);
      pse = 1'b0;
      chk("disarm", 1'b0, we);
      wsel(3'h0, 3'h0);
      chk("held", 1'b1, csn);
      do_reset(1, 1'b0);
      chk("strap", 1'b0, bw);
      chk("role", 1'b0, csn);
      wsel(3'h1, 3'h0);
      do_reset(2, 1'b1);
      chk("strap", 1'b1, bw);
      chk("role", 1'b0, csn);
      final_report();
   end
endmodule

`default_nettype wire
